// [rtl/fabric_pkg.sv]
package fabric_pkg;

  // Local bus indices inside a cell and repeater pair indices
  localparam int VERTICAL_LOCAL_BUS_ONE = 0;
  localparam int HORIZONTAL_LOCAL_BUS_ONE = 1;
  localparam int VERTICAL_LOCAL_BUS_TWO = 2;
  localparam int HORIZONTAL_LOCAL_BUS_TWO = 3;
  localparam int NUM_LOCAL_BUS = 4;
  localparam int NUM_NEIGHBOUR = 4;

  // Repeater segment indices, per bus pair
  localparam int SEG_LOCAL_LEFT = 0;
  localparam int SEG_LOCAL_RIGHT = 1;
  localparam int SEG_EXPRESS_LEFT = 2;
  localparam int SEG_EXPRESS_RIGHT = 3;
  localparam int SEG_PER_PAIR = 4;
  localparam int SECTOR_CELLS = 8;

  // Repeater function codes: 0 isolates, 1..20 are links, 21 in all
  localparam logic [4:0] RPT_FN_ISOLATE = 5'h00;
  localparam logic [4:0] RPT_FN_COUNT = 5'h15;
  localparam logic [4:0] RPT_FN_PER_SRC = 5'h05;

  // APB register byte offsets
  localparam int ADDR_W = 12;
  localparam logic [11:0] CELL_CFG_OFF = 12'h000;
  localparam logic [11:0] COL_CFG_OFF = 12'h004;
  localparam logic [11:0] RPT_CFG_OFF = 12'h008;
  localparam logic [11:0] STATUS_OFF = 12'h00C;

  // Neighbour selector: 0..3 = N,S,E,W, 4 and above = constant one
  localparam logic [2:0] NSEL_ONE = 3'h4;
  // Local-bus selector: 0 = constant one, 1 = first bus, 2 = second bus
  localparam logic [1:0] LSEL_ONE = 2'h0;
  localparam logic [1:0] LSEL_FIRST = 2'h1;
  localparam logic [1:0] LSEL_SECOND = 2'h2;

  typedef enum logic [1:0] {
    FUNC_DIRECT = 2'b00,
    FUNC_SWAP = 2'b01,
    FUNC_XOR_NAND = 2'b10,
    FUNC_REG_AND = 2'b11
  } func_state_t;

  typedef enum logic [1:0] {
    SRC_GLOBAL = 2'b00,
    SRC_EXPRESS = 2'b01,
    SRC_CELL_A = 2'b10,
    SRC_CONST_ONE = 2'b11
  } col_src_t;

  typedef struct packed {
    logic drv_dyn;
    logic drv_gate;
    logic [3:0] pass_gate;
    func_state_t func;
    logic [1:0] r_sel;
    logic [1:0] l_sel;
    logic [2:0] b_sel;
    logic [2:0] a_sel;
  } cell_cfg_t;

  typedef struct packed {
    col_src_t rst_src;
    col_src_t clk_src;
  } col_cfg_t;

  typedef struct packed {
    logic bidir;
    logic [4:0] fn;
  } rpt_cfg_t;

  typedef struct packed {
    logic [15:0] seg_oe;
    logic [3:0] bus_oe;
    logic ff_q;
    logic b_out;
    logic a_out;
  } status_t;

  localparam cell_cfg_t CELL_CFG_RST = '0;
  localparam col_cfg_t COL_CFG_RST = '{rst_src: SRC_CONST_ONE, clk_src: SRC_CONST_ONE};
  localparam logic [23:0] RPT_CFG_RST = 24'h000000;
  // Bidirectional bit exists only on the second bus pairs
  localparam logic [23:0] RPT_WMASK = 24'hFFF7DF;
  localparam logic Q_RST = 1'b0;

endpackage

// [rtl/fabric_tile.sv]
// Operation
// - Cell turns a signal between vertical and horizontal bus one, and bus two.
// - Express buses never touch cells; two express buses per column and row.
// - Repeaters every eight cells cut buses into eight-cell segments, 8x8 sectors.
// - Each repeater serves one local/express pair; one of 21 functions.
// - Repeater functions symmetric under side swap and bus type swap.
// - Repeater isolates, joins local, joins express, transfers; links one-way.
// - Second-pair repeaters add a bidirectional local-to-local link.
// - Reading a bus needs its pass gate on and the selector on it.
// - Writing needs bus and driver pass gates; drive always or under B.
// - A turn enables both pass gates of the bus pair.
// - North, south, east and west sides behave identically.
// - One A and B input per neighbour; single A and B outputs to all.
// - Four-way A and B selectors, each may pick one, feed the AND gates.
// - Two output selectors share one select: function state 0 to 3.
// - State 0: left AND to A, right AND to B.
// - State 1: left AND to B, right AND to A.
// - State 2: A is XOR of AND results, B their NAND.
// - State 3: XOR loads flip-flop driving A; B is AND of results.
// - Configuration gives 44 logical behaviours over 72 physical settings.
// - One cell forms (A and bus one) xor B via left local bus read.
// - Flip-flop clock from global, express, head cell A, or constant one.
// - Column reset from global, express, foot cell A, or constant one; cell flip-flop cleared at power-up, clock edge detector set to one.
module fabric_tile (
  input logic pclk,
  input logic presetn,
  input logic [11:0] paddr,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input logic [3:0] a_in,
  input logic [3:0] b_in,
  output logic a_out,
  output logic b_out,
  input logic [3:0] cell_bus_in,
  input logic [3:0] cell_bus_busy,
  output logic [3:0] cell_bus_out,
  output logic [3:0] cell_bus_oe,
  input logic [15:0] seg_in,
  input logic [15:0] seg_busy,
  output logic [15:0] seg_out,
  output logic [15:0] seg_oe,
  input logic global_clk_pin,
  input logic global_rst_n_pin,
  input logic clk_express,
  input logic rst_express,
  input logic head_a,
  input logic foot_a
);

  fabric_pkg::cell_cfg_t cell_cfg_reg;
  fabric_pkg::cell_cfg_t cell_cfg_next;
  fabric_pkg::col_cfg_t col_cfg_reg;
  fabric_pkg::col_cfg_t col_cfg_next;
  fabric_pkg::rpt_cfg_t [3:0] rpt_cfg_reg;
  fabric_pkg::rpt_cfg_t [3:0] rpt_cfg_next;
  fabric_pkg::status_t status;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic [5:0] ext_sync1_reg;
  logic [5:0] ext_sync2_reg;
  logic clk_prev_reg;
  logic q_reg;
  logic q_next;

  // APB slave, zero wait states
  wire setup_ph = psel & ~penable;
  wire access_ph = psel & penable;
  wire hit_cell = (paddr == fabric_pkg::CELL_CFG_OFF);
  wire hit_col = (paddr == fabric_pkg::COL_CFG_OFF);
  wire hit_rpt = (paddr == fabric_pkg::RPT_CFG_OFF);
  wire hit_stat = (paddr == fabric_pkg::STATUS_OFF);
  wire mapped = hit_cell | hit_col | hit_rpt | hit_stat;
  wire wr_en = access_ph & pwrite;

  assign pready = 1'b1;
  assign pslverr = access_ph & ~mapped;
  assign prdata = prdata_reg;

  // Configuration only moves on a software write
  assign cell_cfg_next = (wr_en & hit_cell) ?
    fabric_pkg::cell_cfg_t'(pwdata[$bits(fabric_pkg::cell_cfg_t)-1:0]) : cell_cfg_reg;
  assign col_cfg_next = (wr_en & hit_col) ?
    fabric_pkg::col_cfg_t'(pwdata[$bits(fabric_pkg::col_cfg_t)-1:0]) : col_cfg_reg;
  assign rpt_cfg_next = (wr_en & hit_rpt) ?
    (pwdata[23:0] & fabric_pkg::RPT_WMASK) : rpt_cfg_reg;

  assign prdata_next = ~setup_ph ? prdata_reg :
    hit_cell ? 32'(cell_cfg_reg) :
    hit_col ? 32'(col_cfg_reg) :
    hit_rpt ? 32'(rpt_cfg_reg) :
    hit_stat ? 32'(status) : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cell_cfg_reg <= fabric_pkg::CELL_CFG_RST;
      col_cfg_reg <= fabric_pkg::COL_CFG_RST;
      rpt_cfg_reg <= fabric_pkg::RPT_CFG_RST;
      prdata_reg <= 32'h00000000;
    end
    else
    begin
      cell_cfg_reg <= cell_cfg_next;
      col_cfg_reg <= col_cfg_next;
      rpt_cfg_reg <= rpt_cfg_next;
      prdata_reg <= prdata_next;
    end
  end

  // Input selectors; every side is treated alike
  wire a_mux = (cell_cfg_reg.a_sel >= fabric_pkg::NSEL_ONE) ? 1'b1 :
    a_in[cell_cfg_reg.a_sel[1:0]];
  wire b_mux = (cell_cfg_reg.b_sel >= fabric_pkg::NSEL_ONE) ? 1'b1 :
    b_in[cell_cfg_reg.b_sel[1:0]];

  // Bus read through pass gate; an open gate reads as one
  logic [3:0] bus_rd_val;
  logic [3:0] bus_read;
  assign bus_rd_val = cell_bus_in | ~cell_cfg_reg.pass_gate;
  assign bus_read[fabric_pkg::VERTICAL_LOCAL_BUS_ONE] =
    (cell_cfg_reg.l_sel == fabric_pkg::LSEL_FIRST);
  assign bus_read[fabric_pkg::HORIZONTAL_LOCAL_BUS_ONE] =
    (cell_cfg_reg.l_sel == fabric_pkg::LSEL_SECOND);
  assign bus_read[fabric_pkg::VERTICAL_LOCAL_BUS_TWO] =
    (cell_cfg_reg.r_sel == fabric_pkg::LSEL_FIRST);
  assign bus_read[fabric_pkg::HORIZONTAL_LOCAL_BUS_TWO] =
    (cell_cfg_reg.r_sel == fabric_pkg::LSEL_SECOND);

  wire l_val = bus_read[fabric_pkg::VERTICAL_LOCAL_BUS_ONE] ?
    bus_rd_val[fabric_pkg::VERTICAL_LOCAL_BUS_ONE] :
    bus_read[fabric_pkg::HORIZONTAL_LOCAL_BUS_ONE] ?
    bus_rd_val[fabric_pkg::HORIZONTAL_LOCAL_BUS_ONE] : 1'b1;
  wire r_val = bus_read[fabric_pkg::VERTICAL_LOCAL_BUS_TWO] ?
    bus_rd_val[fabric_pkg::VERTICAL_LOCAL_BUS_TWO] :
    bus_read[fabric_pkg::HORIZONTAL_LOCAL_BUS_TWO] ?
    bus_rd_val[fabric_pkg::HORIZONTAL_LOCAL_BUS_TWO] : 1'b1;

  // Upstream AND gates and downstream logic
  wire and_left = a_mux & l_val;
  wire and_right = b_mux & r_val;
  wire xor_val = and_left ^ and_right;
  wire and_val = and_left & and_right;

  // Output selectors driven in tandem by one function state
  assign a_out =
    (cell_cfg_reg.func == fabric_pkg::FUNC_DIRECT) ? and_left :
    (cell_cfg_reg.func == fabric_pkg::FUNC_SWAP) ? and_right :
    (cell_cfg_reg.func == fabric_pkg::FUNC_XOR_NAND) ? xor_val :
    q_reg;
  assign b_out =
    (cell_cfg_reg.func == fabric_pkg::FUNC_DIRECT) ? and_right :
    (cell_cfg_reg.func == fabric_pkg::FUNC_SWAP) ? and_left :
    (cell_cfg_reg.func == fabric_pkg::FUNC_XOR_NAND) ? ~and_val :
    and_val;

  // Driver control: always driving, or only while B selector is high
  wire drv_on = cell_cfg_reg.drv_dyn ? b_mux : 1'b1;

  // Per-bus pass gates: read, write, or corner turn to the partner bus
  genvar gb;
  generate
    for (gb = 0; gb < fabric_pkg::NUM_LOCAL_BUS; gb = gb + 1)
    begin : g_bus
      localparam int PARTNER = gb ^ 1;
      wire turn_on = cell_cfg_reg.pass_gate[gb] & cell_cfg_reg.pass_gate[PARTNER] &
        ~bus_read[gb] & ~bus_read[PARTNER] & ~cell_cfg_reg.drv_gate;
      wire turn_drv = turn_on & cell_bus_busy[PARTNER] & ~cell_bus_busy[gb];
      wire write_on = cell_cfg_reg.pass_gate[gb] & cell_cfg_reg.drv_gate &
        ~bus_read[gb];
      assign cell_bus_oe[gb] = turn_drv | (write_on & drv_on);
      assign cell_bus_out[gb] = turn_drv ? cell_bus_in[PARTNER] : a_out;
    end
  endgenerate

  // Repeaters, one per bus pair at the sector edge; express segments only meet them
  genvar gp;
  genvar gd;
  generate
    for (gp = 0; gp < fabric_pkg::NUM_LOCAL_BUS; gp = gp + 1)
    begin : g_rpt
      wire [4:0] fn = rpt_cfg_reg[gp].fn;
      wire fn_ok = (fn != fabric_pkg::RPT_FN_ISOLATE) &
        (fn < fabric_pkg::RPT_FN_COUNT);
      wire [4:0] fm1 = fn - 5'h01;
      wire [4:0] step = fabric_pkg::RPT_FN_PER_SRC;
      // Source segment and link option, each source owning five codes
      wire [1:0] src = (fm1 < step) ? 2'h0 :
        (fm1 < 5'(step + step)) ? 2'h1 :
        (fm1 < 5'(step + step + step)) ? 2'h2 : 2'h3;
      wire [4:0] base = (fm1 < step) ? 5'h00 :
        (fm1 < 5'(step + step)) ? step :
        (fm1 < 5'(step + step + step)) ? 5'(step + step) : 5'(step + step + step);
      wire [4:0] opt = fm1 - base;
      wire [3:0] pin = seg_in[gp*4 +: 4];
      wire [3:0] pbusy = seg_busy[gp*4 +: 4];
      wire bidir_on = rpt_cfg_reg[gp].bidir;
      for (gd = 0; gd < fabric_pkg::SEG_PER_PAIR; gd = gd + 1)
      begin : g_dst
        // Relation by index xor keeps both swaps symmetric
        wire [1:0] rel = 2'(gd) ^ src;
        wire link = fn_ok & (
          ((rel == 2'h1) & ((opt == 5'h00) | (opt == 5'h03) | (opt == 5'h04))) |
          ((rel == 2'h2) & ((opt == 5'h01) | (opt == 5'h04))) |
          ((rel == 2'h3) & ((opt == 5'h02) | (opt == 5'h03))));
        wire bi_drv;
        if (gd < fabric_pkg::SEG_EXPRESS_LEFT && gp >= fabric_pkg::VERTICAL_LOCAL_BUS_TWO)
        begin : g_bi
          assign bi_drv = bidir_on & ~link & pbusy[gd ^ 1] & ~pbusy[gd];
        end
        else
        begin : g_nobi
          assign bi_drv = 1'b0;
        end
        assign seg_oe[gp*4 + gd] = link | bi_drv;
        assign seg_out[gp*4 + gd] = link ? pin[src] : pin[gd ^ 1];
      end
    end
  endgenerate

  // Column clock and reset sources pass a two-stage synchroniser
  wire [5:0] ext_raw = {foot_a, rst_express, global_rst_n_pin,
    head_a, clk_express, global_clk_pin};

  wire clk_lvl =
    (col_cfg_reg.clk_src == fabric_pkg::SRC_GLOBAL) ? ext_sync2_reg[0] :
    (col_cfg_reg.clk_src == fabric_pkg::SRC_EXPRESS) ? ext_sync2_reg[1] :
    (col_cfg_reg.clk_src == fabric_pkg::SRC_CELL_A) ? ext_sync2_reg[2] : 1'b1;
  wire rst_lvl =
    (col_cfg_reg.rst_src == fabric_pkg::SRC_GLOBAL) ? ext_sync2_reg[3] :
    (col_cfg_reg.rst_src == fabric_pkg::SRC_EXPRESS) ? ext_sync2_reg[4] :
    (col_cfg_reg.rst_src == fabric_pkg::SRC_CELL_A) ? ext_sync2_reg[5] : 1'b1;

  wire clk_edge = clk_lvl & ~clk_prev_reg;

  // Column reset wins over a capture edge
  assign q_next = ~rst_lvl ? fabric_pkg::Q_RST :
    clk_edge ? xor_val : q_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_sync1_reg <= 6'h00;
      ext_sync2_reg <= 6'h00;
      clk_prev_reg <= 1'b1;
      q_reg <= fabric_pkg::Q_RST;
    end
    else
    begin
      ext_sync1_reg <= ext_raw;
      ext_sync2_reg <= ext_sync1_reg;
      clk_prev_reg <= clk_lvl;
      q_reg <= q_next;
    end
  end

  assign status.seg_oe = seg_oe;
  assign status.bus_oe = cell_bus_oe;
  assign status.ff_q = q_reg;
  assign status.b_out = b_out;
  assign status.a_out = a_out;

endmodule

// [verification/fabric_tile_chk.sv]
module fabric_tile_chk (
  input logic pclk,
  input logic presetn,
  input logic [11:0] paddr,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic pready,
  input logic [31:0] prdata,
  input logic pslverr,
  input logic [3:0] a_in,
  input logic [3:0] b_in,
  input logic a_out,
  input logic b_out,
  input logic [3:0] cell_bus_oe,
  input logic [15:0] seg_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire rd = acc && !pwrite;
  a_ready_high: assert property (pready)
    else $error("pready not high");
  a_err_unmapped: assert property (acc && paddr > 12'h00C |-> pslverr)
    else $error("no error on unmapped address");
  a_err_mapped: assert property (acc && paddr <= 12'h00C && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped address");
  a_err_setup: assert property (!penable |-> !pslverr)
    else $error("error outside access phase");
  a_data_hold: assert property (acc |=> $stable(prdata))
    else $error("read data moved after access");
  a_bad_read_zero: assert property (rd && pslverr |-> prdata == 32'h0)
    else $error("unmapped read data not zero");
  a_cfg_upper: assert property (rd && paddr == 12'h000 |-> prdata[31:18] == 14'h0)
    else $error("unused config bits not zero");
  a_status_mirror: assert property (rd && paddr == 12'h00C |->
    prdata[31:3] == {9'h0, $past(seg_oe), $past(cell_bus_oe)}
    && prdata[1:0] == {$past(b_out), $past(a_out)})
    else $error("status word differs from outputs");
  a_reset_quiet: assert property ($rose(presetn) |->
    cell_bus_oe == 4'h0 && seg_oe == 16'h0 && a_out == a_in[0] && b_out == b_in[0])
    else $error("outputs not at reset configuration");
  c_unmapped: cover property (acc && pslverr);
  c_write: cover property (acc && pwrite);
  c_repeat: cover property (|seg_oe);
endmodule

bind fabric_tile fabric_tile_chk fabric_tile_chk_i (.*);

// [verification/fabric_bus_model.sv]
module fabric_bus_model (
  input logic pclk,
  input logic [19:0] drv_out,
  input logic [19:0] drv_oe,
  input logic [19:0] ext_val,
  input logic [19:0] ext_on,
  output logic [19:0] lvl,
  output logic [19:0] busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [19:0] last = 20'h0;
  // Far side yields to the cell; a line nobody drives keeps toggling
  assign lvl = (drv_oe & drv_out) | (~drv_oe & ((ext_on & ext_val) | (~ext_on & ~last)));
  assign busy = ext_on & ~drv_oe;
  always @(posedge pclk) last <= lvl;
endmodule

// [verification/fabric_tile_tb.sv]
module fabric_tile_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, a_out, b_out;
  logic [3:0] a_in = 4'h9, b_in = 4'h6, cell_bus_out, cell_bus_oe;
  logic [15:0] seg_out, seg_oe;
  wire [3:0] cell_bus_in, cell_bus_busy;
  wire [15:0] seg_in, seg_busy;
  logic global_clk_pin = 1'b0, global_rst_n_pin = 1'b1;
  logic clk_express = 1'b0, rst_express = 1'b0, head_a = 1'b0, foot_a = 1'b0;
  logic [19:0] ev = 20'h0, eon = 20'h0;
  integer seed = 32'hC6D01ACF;
  int n_fail = 0, num_checks = 0;
  always #2.5 pclk = ~pclk;
  fabric_tile fabric_tile_i (.*);
  fabric_bus_model fabric_bus_model_i (.pclk(pclk), .drv_out({seg_out, cell_bus_out}),
    .drv_oe({seg_oe, cell_bus_oe}), .ext_val(ev), .ext_on(eon),
    .lvl({seg_in, cell_bus_in}), .busy({seg_busy, cell_bus_busy}));
  task automatic results;
    if (n_fail == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [35:0] seen, input logic [35:0] want);
    num_checks++;
    if (seen !== want)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 100)
      n_fail++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle;
    @(posedge pclk);
    #1;
  endtask
  function automatic logic [31:0] cw(logic [2:0] a, logic [2:0] b, logic [1:0] l,
    logic [1:0] r, logic [1:0] f, logic [3:0] pg, logic dg, logic dd);
    return {14'h0, dd, dg, pg, f, r, l, b, a};
  endfunction
  function automatic logic sel(logic [3:0] v, logic [2:0] s);
    return (s >= 3'h4) ? 1'b1 : v[s[1:0]];
  endfunction
  function automatic logic [1:0] fexp(logic la, logic ra, logic [1:0] f);
    case (f)
      2'h0: return {la, ra};
      2'h1: return {ra, la};
      2'h2: return {la ^ ra, ~(la & ra)};
      default: return {la ^ ra, la & ra};
    endcase
  endfunction
  function automatic logic [3:0] rmask(int k);
    int s;
    s = (k - 1) / 5;
    if (k < 1 || k > 20)
      return 4'h0;
    case ((k - 1) % 5)
      0: return 4'h1 << (s ^ 1);
      1: return 4'h1 << (s ^ 2);
      2: return 4'h1 << (s ^ 3);
      3: return (4'h1 << (s ^ 1)) | (4'h1 << (s ^ 3));
      default: return (4'h1 << (s ^ 1)) | (4'h1 << (s ^ 2));
    endcase
  endfunction
  initial
  begin
    logic [2:0] as, bs;
    logic [1:0] f, l;
    logic la, ra;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    settle;
    chk({a_out, b_out}, 2'b10);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, (i == 3) ? 12'h010 : 12'(4 * i), 32'h0);
      chk({er, rd}, {i == 3, (i == 1) ? 32'hF : 32'h0});
    end
    eon <= 20'h1;
    repeat (40)
    begin
      as = 3'($random(seed));
      bs = 3'($random(seed));
      f = 2'($random(seed));
      l = 2'($random(seed)) & 2'h1;
      apb(1'b1, 12'h000, cw(as, bs, l, 2'h0, f, 4'h1, 1'b0, 1'b0));
      a_in <= 4'($random(seed));
      b_in <= 4'($random(seed));
      ev <= 20'($random(seed));
      settle;
      la = sel(a_in, as) & (l == 2'h0 | ev[0]);
      ra = sel(b_in, bs);
      chk({a_out, b_out}, fexp(la, ra, f) & {f != 2'h3, 1'b1});
    end
    for (int j = 0; j < 2; j++)
    begin
      apb(1'b1, 12'h000, cw(3'h4, 3'h4, 2'h0, 2'h0, 2'h0, j ? 4'hC : 4'h3, 1'b0, 1'b0));
      eon <= j ? 20'h8 : 20'h1;
      ev <= 20'($random(seed));
      settle;
      chk({cell_bus_oe, cell_bus_in[j ? 2 : 1]}, {j ? 4'h4 : 4'h2, ev[j ? 3 : 0]});
    end
    eon <= 20'h0;
    for (int j = 0; j < 3; j++)
    begin
      apb(1'b1, 12'h000, cw(3'h4, 3'h0, 2'h0, 2'h0, 2'h0, 4'h2, 1'b1, j > 0));
      b_in <= 4'(j == 2);
      settle;
      chk({cell_bus_oe, cell_bus_out[1]}, {(j == 1) ? 4'h0 : 4'h2, 1'b1});
    end
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, 32'h13);
    eon <= 20'hFFFF0;
    for (int k = 0; k < 22; k++)
    begin
      apb(1'b1, 12'h008, 32'(k));
      ev <= 20'($random(seed));
      settle;
      chk(seg_oe, {12'h0, rmask(k)});
      chk(seg_out[3:0] & rmask(k), ev[(k - 1) / 5 + 4] ? rmask(k) : 4'h0);
    end
    apb(1'b1, 12'h008, 32'hFFFFFF);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h00FFF7DF);
    apb(1'b1, 12'h008, 32'h20000);
    eon <= 20'h01000;
    ev <= 20'($random(seed));
    settle;
    chk({seg_oe, seg_out[9]}, {16'h0200, ev[12]});
    apb(1'b1, 12'h000, cw(3'h4, 3'h0, 2'h0, 2'h0, 2'h3, 4'h0, 1'b0, 1'b0));
    b_in <= 4'h0;
    apb(1'b1, 12'h004, 32'hC);
    global_clk_pin <= 1'b1;
    settle;
    chk({a_out, b_out}, 2'b00);
    repeat (4) settle;
    chk({a_out, b_out}, 2'b10);
    apb(1'b1, 12'h004, 32'h0);
    global_rst_n_pin <= 1'b0;
    repeat (4) settle;
    chk(a_out, 1'b0);
    global_rst_n_pin <= 1'b1;
    apb(1'b1, 12'h004, 32'hD);
    clk_express <= 1'b1;
    repeat (4) settle;
    chk(a_out, 1'b1);
    apb(1'b1, 12'h004, 32'h9);
    repeat (4) settle;
    chk(a_out, 1'b0);
    foot_a <= 1'b1;
    apb(1'b1, 12'h004, 32'hA);
    head_a <= 1'b1;
    repeat (4) settle;
    chk(a_out, 1'b1);
    presetn <= 1'b0;
    repeat (2) settle;
    presetn <= 1'b1;
    settle;
    chk({a_out, b_out, cell_bus_oe, seg_oe}, {a_in[0], b_in[0], 20'h0});
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'hF);
    results;
  end
  initial
  begin
    #20000;
    n_fail++;
    results;
  end
endmodule
